// File: cpa_map.svh
// Offsets, field positions, reset values and key codes of the configuration access unit.
`ifndef CPA_MAP_SVH
`define CPA_MAP_SVH
`define CPA_KEY_UNLOCK 8'h55
`define CPA_KEY_LOCK 8'hAA
`define CPA_IDX_LDN 8'h07
`define CPA_IDX_CFG_CTRL 8'h02
`define CPA_IDX_BASE_LO 8'h26
`define CPA_IDX_BASE_HI 8'h27
`define CPA_SOFT_RST_BIT 0
`define CPA_BASE_STRAP0 8'h2E
`define CPA_BASE_STRAP1 8'h4E
`define CPA_BASE_HI_RST 4'h0
`define CPA_DATA_OFS 12'h001
`define CPA_ZERO_BYTE 8'h00
`endif

// File: cpa_pkg.sv
// Types shared by the configuration access unit.
`default_nettype none
package cpa_pkg;
    typedef enum logic {CPA_RUN, CPA_CONFIG} cpa_state_t;
    typedef logic [7:0] cpa_byte_t;
endpackage : cpa_pkg
`default_nettype wire

// File: cpa_decode.sv
// Port address decoder for the key, index and data ports.
`default_nettype none
`include "cpa_map.svh"
module cpa_decode
    import cpa_pkg::*;
#(
    parameter int AW = 12
) (
    input wire logic [AW-1:0] io_addr, // Host I/O address.
    input wire logic [AW-1:0] base, // Current port base.
    output logic hit_base, // Address is the key/index port.
    output logic hit_data // Address is the data port.
);
    // Refuse other widths at elaboration; the base registers hold exactly twelve bits.
    if (AW != 12) begin : g_bad_aw
        $error("cpa_decode supports a 12-bit base only");
    end
    // The data port sits one byte above the base; base bit 0 is always zero.
    always_comb begin
        hit_base = (io_addr == base);
        hit_data = (io_addr == (base | `CPA_DATA_OFS));
    end
endmodule : cpa_decode
`default_nettype wire

// File: cpa_base_reg.sv
// Relocatable port base registers with strap default and two-step commit.
`default_nettype none
`include "cpa_map.svh"
module cpa_base_reg
    import cpa_pkg::*;
(
    input wire logic clk, // Clock.
    input wire logic rstn, // Asynchronous active-low reset.
    input wire logic hard_rst, // Synchronous hard reset request.
    input wire logic ce, // Clock enable.
    input wire logic strap, // Base select strap.
    input wire logic wr_lo, // Write low base byte.
    input wire logic wr_hi, // Write high base bits.
    input wire cpa_byte_t wdata, // Write data.
    output cpa_byte_t lo_rd, // Low register readback.
    output cpa_byte_t hi_rd, // High register readback.
    output logic [11:0] base // Active decode base.
);
    logic [7:1] lo_ff, nxt_lo;
    logic [3:0] hi_ff, nxt_hi;
    logic [11:1] act_ff, nxt_act;
    logic [7:0] strap_lo;
    // Hard reset reloads from strap; soft reset never reaches here.
    always_comb begin
        strap_lo = strap ? `CPA_BASE_STRAP1 : `CPA_BASE_STRAP0;
        nxt_lo = lo_ff;
        nxt_hi = hi_ff;
        nxt_act = act_ff;
        if (hard_rst) begin
            nxt_lo = strap_lo[7:1];
            nxt_hi = `CPA_BASE_HI_RST;
            nxt_act = {`CPA_BASE_HI_RST, strap_lo[7:1]};
        end else begin
            if (wr_lo) nxt_lo = wdata[7:1];
            if (wr_hi) begin
                nxt_hi = wdata[3:0];
                nxt_act = {wdata[3:0], lo_ff};
            end
        end
    end
    // Async reset gives a fixed value; strap is caught by the first hard reset cycle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lo_ff <= 7'h17;
            hi_ff <= 4'h0;
            act_ff <= 11'h017;
        end else if (ce) begin
            lo_ff <= nxt_lo;
            hi_ff <= nxt_hi;
            act_ff <= nxt_act;
        end
    end
    assign lo_rd = {lo_ff, 1'b0};
    assign hi_rd = {4'h0, hi_ff};
    assign base = {act_ff, 1'b0};
    a_hi_commit: assert property (@(posedge clk) disable iff (!rstn)
        ce && wr_hi && !hard_rst |=> base == {$past(wdata[3:0]), $past(lo_ff), 1'b0})
        else $error("high write did not move base");
    a_lo_hold: assert property (@(posedge clk) disable iff (!rstn)
        ce && wr_lo && !wr_hi && !hard_rst |=> $stable(base))
        else $error("low write moved base");
    a_strap_load: assert property (@(posedge clk) disable iff (!rstn)
        ce && hard_rst |=> base == ($past(strap) ? 12'h04E : 12'h02E))
        else $error("hard reset base wrong");
endmodule : cpa_base_reg
`default_nettype wire

// File: cpa_top.sv
// Configuration port access unit: key lock, index/data ports and global registers.
// Notes on behaviour
// - Only run and configuration states; run accepts the unlock key unless a hard reset is active.
// - Writing 0x55 to the key port in run enters configuration.
// - Writing 0xAA to the key port in configuration returns to run.
// - Index and data ports work only in configuration; ignored in run.
// - Key port reads in run leave the data bus undriven.
// - After unlock and before another port write, key port reads return 0x00.
// - After an index write, port reads return the last index value.
// - Then index selects a register, read or written through the data port.
// - Global registers need no logical device selection.
// - Default base is 0x02E with strap low, 0x04E with strap high.
// - Base is even, bit zero fixed, within 0x0000 to 0x0FFE.
// - Low register holds bits 7..1; high holds bits 11..8 in low nibble.
// - High register write moves decode; low write alone does not.
// - Hard reset loads base from strap, high bits zero.
// - Soft reset leaves both base registers unchanged.
// - Hard reset follows main supply power-on or reset output pin.
// - Host writing one to config control bit 0 causes a soft reset.
`default_nettype none
`include "cpa_map.svh"
module cpa_top
    import cpa_pkg::*;
(
    input wire logic clk, // Host bus clock, 25 MHz.
    input wire logic rstn, // Asynchronous active-low reset.
    input wire logic ce, // Clock enable; freezes all state when low.
    input wire logic main_supply_power_on_reset, // Main supply power-on reset, high active.
    input wire logic system_reset_output_pin, // Reset output pin asserted, high active.
    input wire logic mode_strap, // Base select strap.
    input wire logic [11:0] io_addr, // Host I/O address.
    input wire logic io_wr, // Host I/O write strobe, one cycle.
    input wire logic io_rd, // Host I/O read strobe, one cycle.
    input wire cpa_byte_t io_wdata, // Host write data.
    output cpa_byte_t io_rdata, // Read data, registered.
    output logic io_rdata_oe, // High while the unit drives read data.
    output cpa_byte_t ldn, // Selected logical device number.
    output cpa_byte_t ld_index, // Per-device register index.
    output logic ld_wr, // Per-device register write pulse.
    output logic ld_rd, // Per-device register read pulse.
    output cpa_byte_t ld_wdata, // Per-device write data.
    input wire cpa_byte_t ld_rdata, // Per-device read data.
    output logic soft_reset, // Soft reset pulse to logical devices.
    output logic in_config // High in the configuration state.
);
    // Lock state group.
    cpa_state_t state_ff, nxt_state;
    // Index and device group, including the one-cycle pulses to the logical devices.
    cpa_byte_t index_ff, nxt_index;
    cpa_byte_t ldn_ff, nxt_ldn;
    logic idx_seen_ff, nxt_idx_seen;
    logic soft_ff, nxt_soft;
    logic ldwr_ff, nxt_ldwr;
    logic ldrd_ff, nxt_ldrd;
    cpa_byte_t ldwd_ff, nxt_ldwd;
    // Read group; the enable stands for exactly one cycle after a served read.
    cpa_byte_t rdata_ff, nxt_rdata;
    logic oe_ff, nxt_oe;
    // Port decode and base register wires.
    logic hit_base, hit_data;
    logic hard_rst, cfg, wr_lo, wr_hi;
    cpa_byte_t lo_rd, hi_rd;
    logic [11:0] base;

    // Global indices live below 0x30; from 0x30 up, accesses go to the selected device.
    // Reserved global indices read back zero and never reach a logical device.
    function automatic logic is_global(input cpa_byte_t idx);
        is_global = (idx < 8'h30);
    endfunction : is_global

    assign hard_rst = main_supply_power_on_reset | system_reset_output_pin;
    assign cfg = (state_ff == CPA_CONFIG);
    // Base registers are written only through the data port in configuration.
    assign wr_lo = cfg && io_wr && hit_data && index_ff == `CPA_IDX_BASE_LO;
    assign wr_hi = cfg && io_wr && hit_data && index_ff == `CPA_IDX_BASE_HI;

    // The decoder compares against the committed base only, never the pending low byte.
    cpa_decode #(.AW(12)) u_dec (
        .io_addr(io_addr),
        .base(base),
        .hit_base(hit_base),
        .hit_data(hit_data)
    );

    // Base registers; their strap default loads on every hard reset cycle.
    cpa_base_reg u_base (
        .clk(clk),
        .rstn(rstn),
        .hard_rst(hard_rst),
        .ce(ce),
        .strap(mode_strap),
        .wr_lo(wr_lo),
        .wr_hi(wr_hi),
        .wdata(io_wdata),
        .lo_rd(lo_rd),
        .hi_rd(hi_rd),
        .base(base)
    );

    // Lock state machine; only keys on the base port and hard reset move it.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            CPA_RUN: begin
                if (io_wr && hit_base && io_wdata == `CPA_KEY_UNLOCK) nxt_state = CPA_CONFIG;
                // Any other value written in run leaves the state alone.
            end
            CPA_CONFIG: begin
                if (io_wr && hit_base && io_wdata == `CPA_KEY_LOCK) nxt_state = CPA_RUN;
            end
            default: nxt_state = CPA_RUN;
        endcase
        // A hard reset outranks any key written in the same cycle.
        if (hard_rst) nxt_state = CPA_RUN;
    end

    // Index, device number and soft reset. The index port shares the key port address,
    // so a lock key also lands in the index; it is harmless once the unit is locked.
    always_comb begin
        nxt_index = index_ff;
        nxt_ldn = ldn_ff;
        nxt_idx_seen = idx_seen_ff;
        nxt_soft = 1'b0;
        nxt_ldwr = 1'b0;
        nxt_ldrd = 1'b0;
        nxt_ldwd = ldwd_ff;
        if (cfg && io_wr && hit_base) begin
            nxt_index = io_wdata;
            nxt_idx_seen = 1'b1;
        end
        if (!cfg && io_wr && hit_base && io_wdata == `CPA_KEY_UNLOCK) begin
            nxt_idx_seen = 1'b0;
        end
        if (cfg && io_wr && hit_data) begin
            if (index_ff == `CPA_IDX_LDN) nxt_ldn = io_wdata;
            if (index_ff == `CPA_IDX_CFG_CTRL) nxt_soft = io_wdata[`CPA_SOFT_RST_BIT];
            if (!is_global(index_ff)) begin
                nxt_ldwr = 1'b1;
                nxt_ldwd = io_wdata;
            end
        end
        if (cfg && io_rd && hit_data && !is_global(index_ff)) nxt_ldrd = 1'b1;
        // A soft reset deselects the device on the cycle after its pulse; the base is untouched.
        if (soft_ff) nxt_ldn = `CPA_ZERO_BYTE;
        // A hard reset clears the index so the next unlock starts from a known point.
        if (hard_rst) begin
            nxt_index = `CPA_ZERO_BYTE;
            nxt_ldn = `CPA_ZERO_BYTE;
            nxt_idx_seen = 1'b0;
        end
    end

    // Read path: the key port floats in run, and the data port answers only in config.
    always_comb begin
        nxt_rdata = rdata_ff;
        nxt_oe = 1'b0;
        if (io_rd && cfg && hit_base) begin
            nxt_oe = 1'b1;
            nxt_rdata = idx_seen_ff ? index_ff : `CPA_ZERO_BYTE;
        end else if (io_rd && cfg && hit_data) begin
            nxt_oe = 1'b1;
            // Device data is taken straight from ld_rdata, so it must stand in the read cycle.
            case (index_ff)
                `CPA_IDX_LDN: nxt_rdata = ldn_ff;
                `CPA_IDX_BASE_LO: nxt_rdata = lo_rd;
                `CPA_IDX_BASE_HI: nxt_rdata = hi_rd;
                default: nxt_rdata = is_global(index_ff) ? `CPA_ZERO_BYTE : ld_rdata;
            endcase
        end
        // A run-state read of the key port leaves oe low.
    end

    // Lock state register; the clock enable freezes it with everything else.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= CPA_RUN;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    // Index and device group registers.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            index_ff <= 8'h00;
            ldn_ff <= 8'h00;
            idx_seen_ff <= 1'b0;
            soft_ff <= 1'b0;
            ldwr_ff <= 1'b0;
            ldrd_ff <= 1'b0;
            ldwd_ff <= 8'h00;
        end else if (ce) begin
            index_ff <= nxt_index;
            ldn_ff <= nxt_ldn;
            idx_seen_ff <= nxt_idx_seen;
            soft_ff <= nxt_soft;
            ldwr_ff <= nxt_ldwr;
            ldrd_ff <= nxt_ldrd;
            ldwd_ff <= nxt_ldwd;
        end
    end

    // Read group registers.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= 8'h00;
            oe_ff <= 1'b0;
        end else if (ce) begin
            rdata_ff <= nxt_rdata;
            oe_ff <= nxt_oe;
        end
    end

    // Outputs come straight from the registers; in_config is a decode of the state register.
    assign io_rdata = rdata_ff;
    assign io_rdata_oe = oe_ff;
    assign ldn = ldn_ff;
    assign ld_index = index_ff;
    assign ld_wr = ldwr_ff;
    assign ld_rd = ldrd_ff;
    assign ld_wdata = ldwd_ff;
    assign soft_reset = soft_ff;
    assign in_config = cfg;

    // Checks on the lock machine and port gating.
    // The key and index sequences leave one quiet cycle between write and read, as a host does.
    a_unlock_enter: assert property (@(posedge clk) disable iff (!rstn)
        ce && !hard_rst && !cfg && io_wr && hit_base && io_wdata == 8'h55 |=> in_config)
        else $error("unlock key did not enter config");

    a_lock_exit: assert property (@(posedge clk) disable iff (!rstn)
        ce && !hard_rst && cfg && io_wr && hit_base && io_wdata == 8'hAA |=> !in_config)
        else $error("lock key did not exit config");

    a_run_ignore: assert property (@(posedge clk) disable iff (!rstn)
        ce && !cfg && !(io_wr && hit_base && io_wdata == 8'h55) |=> !in_config)
        else $error("run left without unlock key");

    a_run_float: assert property (@(posedge clk) disable iff (!rstn)
        ce && !cfg |=> !io_rdata_oe)
        else $error("data driven in run");

    a_zero_after_key: assert property (@(posedge clk) disable iff (!rstn)
        ce && !hard_rst && !cfg && io_wr && hit_base && io_wdata == 8'h55 ##1
        ce && !hard_rst && !io_wr ##1
        ce && io_rd && hit_base && !io_wr |=> io_rdata == 8'h00 && io_rdata_oe)
        else $error("key port not zero after unlock");

    a_index_echo: assert property (@(posedge clk) disable iff (!rstn)
        ce && !hard_rst && cfg && io_wr && hit_base && io_wdata != 8'hAA ##1
        ce && !hard_rst && !io_wr ##1
        ce && io_rd && hit_base && !io_wr |=> io_rdata == $past(io_wdata, 3))
        else $error("index readback wrong");

    a_ldn_store: assert property (@(posedge clk) disable iff (!rstn)
        ce && !hard_rst && !soft_ff && cfg && io_wr && hit_data && index_ff == 8'h07
        |=> ldn == $past(io_wdata))
        else $error("device number not stored");

    a_soft_pulse: assert property (@(posedge clk) disable iff (!rstn)
        ce && cfg && io_wr && hit_data && index_ff == 8'h02 && io_wdata[0] |=> soft_reset)
        else $error("soft reset not raised");

    a_soft_base: assert property (@(posedge clk) disable iff (!rstn)
        ce && soft_reset && !hard_rst && !wr_hi |=> $stable(base))
        else $error("soft reset moved base");

    // Checks on hard reset, decode and the device pulses.
    a_hard_run: assert property (@(posedge clk) disable iff (!rstn)
        ce && hard_rst |=> !in_config)
        else $error("hard reset left config open");

    a_run_no_dev: assert property (@(posedge clk) disable iff (!rstn)
        ce && !cfg |=> !ld_wr && !ld_rd && !soft_reset)
        else $error("device pulse in run");

    a_global_no_dev: assert property (@(posedge clk) disable iff (!rstn)
        ce && cfg && io_wr && hit_data && index_ff < 8'h30 |=> !ld_wr)
        else $error("global write reached a device");

    a_read_idle: assert property (@(posedge clk) disable iff (!rstn)
        ce && !io_rd |=> !io_rdata_oe)
        else $error("data driven without a read");

    a_data_port: assert property (@(posedge clk) disable iff (!rstn)
        ce && cfg && io_rd && io_addr == base + 12'h001 |=> io_rdata_oe)
        else $error("data port read not served");

    a_ldn_soft: assert property (@(posedge clk) disable iff (!rstn)
        ce && soft_reset && !hard_rst |=> ldn == 8'h00)
        else $error("soft reset kept the device number");

    // Scenarios that the bench is expected to reach.
    c_unlock: cover property (@(posedge clk) !cfg ##1 cfg);
    c_relocate: cover property (@(posedge clk) wr_lo ##[1:8] wr_hi);
    c_dev_write: cover property (@(posedge clk) ld_wr);
    c_lock: cover property (@(posedge clk) cfg ##1 !cfg);
    c_soft_reset: cover property (@(posedge clk) soft_reset);
endmodule : cpa_top
`default_nettype wire

// File: cpa_host_model.sv
// Host bus controller model that issues one-cycle I/O cycles to the unit.
`default_nettype none
module cpa_host_model
    import cpa_pkg::*;
(
    input wire logic clk, // Clock.
    output logic [11:0] io_addr, // I/O address.
    output logic io_wr, // Write strobe.
    output logic io_rd, // Read strobe.
    output cpa_byte_t io_wdata, // Write data.
    input wire cpa_byte_t io_rdata, // Read data from the unit.
    input wire logic io_rdata_oe // High while read data is driven.
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus at time zero.
    initial begin
        io_addr = 12'h000;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end
    // One write; the data lines are inverted on release so a stale value never looks valid.
    task automatic wr(input logic [11:0] a, input cpa_byte_t d);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
        io_wdata <= ~d;
        @(posedge clk);
    endtask : wr
    // One read; the answer is registered, so it is taken mid-cycle after the strobe edge.
    task automatic rd(input logic [11:0] a, output cpa_byte_t d, output logic oe);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
        @(negedge clk);
        d = io_rdata;
        oe = io_rdata_oe;
        @(posedge clk);
    endtask : rd
endmodule : cpa_host_model
`default_nettype wire

// File: test_config_port_access_unit.sv
// Self-checking testbench of the configuration port access unit.
`default_nettype none
`include "cpa_map.svh"
module test_config_port_access_unit
    import cpa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rstn, ce, por, pin, mode_strap, io_wr, io_rd, io_rdata_oe, ld_wr, ld_rd;
    logic soft_reset, in_config;
    logic [11:0] io_addr, b;
    cpa_byte_t io_wdata, io_rdata, ldn, ld_index, ld_wdata, ld_rdata;
    int bad_count, n_compared, wr_n, rd_n, sr_n;
    cpa_host_model u_host (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe));
    cpa_top u_dut (.clk(clk), .rstn(rstn), .ce(ce), .main_supply_power_on_reset(por),
        .system_reset_output_pin(pin), .mode_strap(mode_strap), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_rdata_oe(io_rdata_oe), .ldn(ldn), .ld_index(ld_index), .ld_wr(ld_wr),
        .ld_rd(ld_rd), .ld_wdata(ld_wdata), .ld_rdata(ld_rdata), .soft_reset(soft_reset),
        .in_config(in_config));
    // 25 MHz clock.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Count one-cycle pulses at mid-cycle, where they are settled and clear of the launch edge.
    always @(negedge clk) begin
        wr_n += int'(ld_wr === 1'b1);
        rd_n += int'(ld_rd === 1'b1);
        sr_n += int'(soft_reset === 1'b1);
    end
    task automatic chk(input string nm, input cpa_byte_t e, input cpa_byte_t g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Read a port and compare the drive enable, and the data when it is driven.
    task automatic rdchk(input logic [11:0] a, input logic eoe, input cpa_byte_t e);
        cpa_byte_t d;
        logic oe;
        u_host.rd(a, d, oe);
        chk("read enable", {7'h00, eoe}, {7'h00, oe});
        if (eoe) chk("read data", e, d);
    endtask : rdchk
    task automatic hard(input logic use_pin, input logic s);
        mode_strap <= s;
        if (use_pin) pin <= 1'b1;
        else por <= 1'b1;
        @(posedge clk);
        pin <= 1'b0;
        por <= 1'b0;
        @(posedge clk);
    endtask : hard
    task automatic t_lock();
        rdchk(b, 1'b0, 8'h00);
        u_host.wr(b, 8'h12);
        chk("state", 8'h00, {7'h00, in_config});
        u_host.wr(b, `CPA_IDX_LDN);
        u_host.wr(b + `CPA_DATA_OFS, 8'h05);
        u_host.wr(b, `CPA_KEY_UNLOCK);
        chk("state", 8'h01, {7'h00, in_config});
        chk("ldn", 8'h00, ldn);
        rdchk(b, 1'b1, 8'h00);
        u_host.wr(b, 8'h26);
        rdchk(b, 1'b1, 8'h26);
        u_host.wr(b, `CPA_KEY_LOCK);
        chk("state", 8'h00, {7'h00, in_config});
        rdchk(b, 1'b0, 8'h00);
        $display("test lock done");
    endtask : t_lock
    task automatic t_global();
        u_host.wr(b, `CPA_KEY_UNLOCK);
        u_host.wr(b, `CPA_IDX_BASE_LO);
        rdchk(b + `CPA_DATA_OFS, 1'b1, `CPA_BASE_STRAP0);
        u_host.wr(b, `CPA_IDX_BASE_HI);
        rdchk(b + `CPA_DATA_OFS, 1'b1, 8'h00);
        $display("test global done");
    endtask : t_global
    task automatic t_ldev();
        u_host.wr(b, `CPA_IDX_LDN);
        u_host.wr(b + `CPA_DATA_OFS, 8'h08);
        chk("ldn", 8'h08, ldn);
        u_host.wr(b, 8'hE0);
        u_host.wr(b + `CPA_DATA_OFS, 8'h02);
        chk("ld index", 8'hE0, ld_index);
        chk("ld wdata", 8'h02, ld_wdata);
        chk("ld writes", 8'h01, 8'(wr_n));
        ld_rdata <= 8'h5A;
        rdchk(b + `CPA_DATA_OFS, 1'b1, 8'h5A);
        chk("ld reads", 8'h01, 8'(rd_n));
        $display("test ldev done");
    endtask : t_ldev
    task automatic t_reloc();
        u_host.wr(b, `CPA_IDX_BASE_LO);
        u_host.wr(b + `CPA_DATA_OFS, 8'h61);
        rdchk(b, 1'b1, `CPA_IDX_BASE_LO);
        rdchk(b + `CPA_DATA_OFS, 1'b1, 8'h60);
        u_host.wr(b, `CPA_IDX_BASE_HI);
        u_host.wr(b + `CPA_DATA_OFS, 8'hF3);
        rdchk(b, 1'b0, 8'h00);
        b = 12'h360;
        rdchk(b, 1'b1, `CPA_IDX_BASE_HI);
        rdchk(b + `CPA_DATA_OFS, 1'b1, 8'h03);
        $display("test reloc done");
    endtask : t_reloc
    task automatic t_soft();
        u_host.wr(b, `CPA_IDX_CFG_CTRL);
        u_host.wr(b + `CPA_DATA_OFS, 8'h01);
        chk("soft resets", 8'h01, 8'(sr_n));
        u_host.wr(b, `CPA_IDX_BASE_LO);
        chk("ldn", 8'h00, ldn);
        rdchk(b + `CPA_DATA_OFS, 1'b1, 8'h60);
        $display("test soft done");
    endtask : t_soft
    task automatic t_hard();
        hard(1'b1, 1'b1);
        chk("state", 8'h00, {7'h00, in_config});
        b = 12'h04E;
        u_host.wr(b, `CPA_KEY_UNLOCK);
        chk("state", 8'h01, {7'h00, in_config});
        u_host.wr(b, `CPA_IDX_BASE_LO);
        rdchk(b + `CPA_DATA_OFS, 1'b1, `CPA_BASE_STRAP1);
        hard(1'b0, 1'b0);
        b = 12'h02E;
        u_host.wr(b, `CPA_KEY_UNLOCK);
        chk("state", 8'h01, {7'h00, in_config});
        u_host.wr(b, `CPA_KEY_LOCK);
        $display("test hard done");
    endtask : t_hard
    // A low clock enable must swallow an unlock key; the same key lands once it is high.
    task automatic t_freeze();
        ce <= 1'b0;
        u_host.wr(b, `CPA_KEY_UNLOCK);
        chk("frozen state", 8'h00, {7'h00, in_config});
        ce <= 1'b1;
        u_host.wr(b, `CPA_KEY_UNLOCK);
        chk("state", 8'h01, {7'h00, in_config});
        u_host.wr(b, `CPA_KEY_LOCK);
        chk("state", 8'h00, {7'h00, in_config});
        $display("test freeze done");
    endtask : t_freeze
    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    // Cut a hang short.
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        summarize();
    end
    // Main sequence.
    initial begin
        {rstn, por, pin, mode_strap} = 4'h0;
        ce = 1'b1;
        ld_rdata = 8'h00;
        b = 12'h02E;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        hard(1'b0, 1'b0);
        t_lock();
        t_global();
        t_ldev();
        t_reloc();
        t_soft();
        t_hard();
        t_freeze();
        summarize();
    end
endmodule : test_config_port_access_unit
`default_nettype wire
